// [hw/fpec_top.sv]
// Purpose: flash program/erase sequencer with control register and interrupt
// Assumes: nrst_in is the power-on reset; soft_rst_in covers all other resets
// Notes: the flash array is driven by level strobes for the timed duration plus one cycle
`timescale 1ns/1ps
`default_nettype none
module fpec_top import fpec_pkg::*; #(
	parameter int PROG_CYCLES = PROG_CYC_DEF,
	parameter int ERASE_CYCLES = ERASE_CYC_DEF,
	parameter logic [3:0] PROG_OP_CODE = PROG_OP_DEF,
	parameter logic [15:0] KEY1_VALUE = KEY1_DEF,
	parameter logic [15:0] KEY2_VALUE = KEY2_DEF
) (
	input wire logic clk_in,
	input wire logic nrst_in,
	input wire logic soft_rst_in,
	input wire logic [AXI_AW-1:0] s_axi_awaddr_in,
	input wire logic s_axi_awvalid_in,
	output logic s_axi_awready_out,
	input wire logic [31:0] s_axi_wdata_in,
	input wire logic [3:0] s_axi_wstrb_in,
	input wire logic s_axi_wvalid_in,
	output logic s_axi_wready_out,
	output logic [1:0] s_axi_bresp_out,
	output logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	input wire logic [AXI_AW-1:0] s_axi_araddr_in,
	input wire logic s_axi_arvalid_in,
	output logic s_axi_arready_out,
	output logic [31:0] s_axi_rdata_out,
	output logic [1:0] s_axi_rresp_out,
	output logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in,
	output logic flash_erase_out,
	output logic flash_prog_out,
	output logic [3:0] flash_op_out,
	output logic irq_out
);
	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		fpec_seq_type state;
		logic trigger;
		logic allow;
		logic seqerr;
		logic erase;
		logic [3:0] op;
		fpec_key_type key;
		logic [IRQ_W-1:0] stat;
		logic [IRQ_W-1:0] mask;
		logic irq;
		logic f_erase;
		logic f_prog;
		logic [3:0] f_op;
	} fpec_state_type;
	fpec_state_type r, n;

	logic wr_en;
	logic [AXI_AW-1:0] wr_addr;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;
	logic wr_err;
	logic rd_en;
	logic [AXI_AW-1:0] rd_addr;
	logic [31:0] rd_data;
	logic rd_err;
	logic tmr_done;
	logic tmr_run;
	logic attempt;
	logic abort;
	logic start_e;
	logic start_p;
	logic err_evt;
	logic done_evt;
	logic [TMR_W-1:0] tmr_cycles;
	logic [15:0] ctl_word;

	// ****************************************
	// bus front end and timer
	// ****************************************
	fpec_axil u_axil (
		.clk_in(clk_in),
		.nrst_in(nrst_in),
		.awaddr_in(s_axi_awaddr_in),
		.awvalid_in(s_axi_awvalid_in),
		.awready_out(s_axi_awready_out),
		.wdata_in(s_axi_wdata_in),
		.wstrb_in(s_axi_wstrb_in),
		.wvalid_in(s_axi_wvalid_in),
		.wready_out(s_axi_wready_out),
		.bresp_out(s_axi_bresp_out),
		.bvalid_out(s_axi_bvalid_out),
		.bready_in(s_axi_bready_in),
		.araddr_in(s_axi_araddr_in),
		.arvalid_in(s_axi_arvalid_in),
		.arready_out(s_axi_arready_out),
		.rdata_out(s_axi_rdata_out),
		.rresp_out(s_axi_rresp_out),
		.rvalid_out(s_axi_rvalid_out),
		.rready_in(s_axi_rready_in),
		.wr_en_out(wr_en),
		.wr_addr_out(wr_addr),
		.wr_data_out(wr_data),
		.wr_strb_out(wr_strb),
		.wr_err_in(wr_err),
		.rd_en_out(rd_en),
		.rd_addr_out(rd_addr),
		.rd_data_in(rd_data),
		.rd_err_in(rd_err)
	);

	fpec_timer #(
		.W(TMR_W)
	) u_timer (
		.clk_in(clk_in),
		.nrst_in(nrst_in),
		.start_in(start_e || start_p),
		.abort_in(abort),
		.cycles_in(tmr_cycles),
		.done_out(tmr_done),
		.running_out(tmr_run)
	);

	// ****************************************
	// register read decode
	// ****************************************
	always_comb begin
		ctl_word = 16'h0000;
		ctl_word[CTL_TRIG_BIT] = r.trigger;
		ctl_word[CTL_ALLOW_BIT] = r.allow;
		ctl_word[CTL_ERR_BIT] = r.seqerr;
		ctl_word[CTL_ERASE_BIT] = r.erase;
		ctl_word[CTL_OP_MSB:CTL_OP_LSB] = r.op;
		rd_err = 1'b0;
		rd_data = 32'h00000000;
		case (rd_addr)
			OFS_CTL: rd_data = {16'h0000, ctl_word};
			OFS_STAT: rd_data = {30'h00000000, r.stat};
			OFS_MASK: rd_data = {30'h00000000, r.mask};
			OFS_KEY: rd_data = {30'h00000000, r.key};
			default: rd_err = 1'b1;
		endcase
		wr_err = !(wr_addr == OFS_CTL || wr_addr == OFS_STAT || wr_addr == OFS_MASK || wr_addr == OFS_KEY);
	end

	// ****************************************
	// sequencer
	// ****************************************
	always_comb begin
		n = r;
		attempt = 1'b0;
		start_e = 1'b0;
		start_p = 1'b0;
		err_evt = 1'b0;
		done_evt = 1'b0;
		tmr_cycles = TMR_W'(PROG_CYCLES);
		// other resets drop the unlock only; control bits keep power-on reset
		if (soft_rst_in) begin
			n.key = FPEC_KEY_NONE;
		end
		// ****************************************
		// unlock keys
		// ****************************************
		if (wr_en && wr_addr == OFS_KEY && wr_strb[1:0] == 2'h3) begin
			if (r.key == FPEC_KEY_NONE && wr_data[15:0] == KEY1_VALUE) begin
				n.key = FPEC_KEY_HALF;
			end else if (r.key == FPEC_KEY_HALF && wr_data[15:0] == KEY2_VALUE) begin
				n.key = FPEC_KEY_OPEN;
			end else begin
				n.key = FPEC_KEY_NONE;
			end
		end
		// ****************************************
		// control register write
		// ****************************************
		if (wr_en && wr_addr == OFS_CTL) begin
			if (wr_strb[1]) begin
				n.allow = wr_data[CTL_ALLOW_BIT];
				if (!wr_data[CTL_ERR_BIT]) begin
					n.seqerr = 1'b0;
				end
				// a written zero never clears the trigger
				attempt = wr_data[CTL_TRIG_BIT] && r.state == FPEC_IDLE;
			end
			// mode and code frozen while an operation runs
			if (wr_strb[0] && r.state == FPEC_IDLE) begin
				n.erase = wr_data[CTL_ERASE_BIT];
				n.op = wr_data[CTL_OP_MSB:CTL_OP_LSB];
			end
		end
		// ****************************************
		// start decision
		// ****************************************
		if (attempt) begin
			// each attempt consumes the unlock, success or not
			n.key = FPEC_KEY_NONE;
			if (!n.allow || r.key != FPEC_KEY_OPEN) begin
				err_evt = 1'b1;
			end else if (n.erase && n.op == OP_PAGE_ERASE) begin
				start_e = 1'b1;
			end else if (!n.erase && n.op == PROG_OP_CODE) begin
				start_p = 1'b1;
			end
			// no-op, reserved and undefined codes leave the trigger clear
		end
		// done wins over an abort in the same cycle
		abort = r.state != FPEC_IDLE && !n.allow && !tmr_done;
		if (start_e) begin
			tmr_cycles = TMR_W'(ERASE_CYCLES);
		end
		// ****************************************
		// operation state
		// ****************************************
		case (r.state)
			FPEC_IDLE: begin
				if (start_e) begin
					n.state = FPEC_ERASE;
					n.trigger = 1'b1;
				end else if (start_p) begin
					n.state = FPEC_PROG;
					n.trigger = 1'b1;
				end
			end
			FPEC_ERASE, FPEC_PROG: begin
				if (tmr_done) begin
					n.state = FPEC_IDLE;
					n.trigger = 1'b0;
					done_evt = 1'b1;
				end else if (abort) begin
					n.state = FPEC_IDLE;
					n.trigger = 1'b0;
					err_evt = 1'b1;
				end
			end
			default: begin
				n.state = FPEC_IDLE;
				n.trigger = 1'b0;
			end
		endcase
		if (err_evt) begin
			n.seqerr = 1'b1;
		end
		// ****************************************
		// interrupt status, write one to clear, set wins
		// ****************************************
		if (wr_en && wr_addr == OFS_STAT && wr_strb[0]) begin
			n.stat = r.stat & ~wr_data[IRQ_W-1:0];
		end
		if (wr_en && wr_addr == OFS_MASK && wr_strb[0]) begin
			n.mask = wr_data[IRQ_W-1:0];
		end
		if (done_evt) begin
			n.stat[IRQ_DONE_BIT] = 1'b1;
		end
		if (err_evt) begin
			n.stat[IRQ_ERR_BIT] = 1'b1;
		end
		n.irq = |(n.stat & n.mask);
		// ****************************************
		// flash strobes
		// ****************************************
		// a strobe outlasts the count by the cycle in which done is seen
		n.f_erase = n.state == FPEC_ERASE;
		n.f_prog = n.state == FPEC_PROG;
		n.f_op = n.op;
	end

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	assign flash_erase_out = r.f_erase;
	assign flash_prog_out = r.f_prog;
	assign flash_op_out = r.f_op;
	assign irq_out = r.irq;

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!nrst_in);

	sequence seq_good_start;
		attempt && n.allow && r.key == FPEC_KEY_OPEN;
	endsequence
	sequence seq_erase_run;
		r.trigger && flash_erase_out && !flash_prog_out;
	endsequence
	sequence seq_prog_run;
		r.trigger && flash_prog_out && !flash_erase_out;
	endsequence

	AST_TRIG_DONE: assert property (tmr_done && r.state != FPEC_IDLE |=> !r.trigger && r.stat[IRQ_DONE_BIT])
		else $error("trigger not cleared at completion");
	AST_STROBE_EXCL: assert property (!(flash_erase_out && flash_prog_out))
		else $error("erase and program strobes together");
	AST_TRIG_NO_SW_CLEAR: assert property ($fell(r.trigger) |-> $past(tmr_done) || $past(abort))
		else $error("trigger cleared without completion");
	AST_TRIG_HOLD: assert property (r.trigger && !tmr_done && !abort |=> r.trigger)
		else $error("trigger dropped while the operation runs");
	AST_IDLE_ZERO: assert property (r.trigger == (flash_erase_out || flash_prog_out))
		else $error("trigger disagrees with sequencer activity");
	AST_INHIBIT: assert property (attempt && !n.allow |=> !r.trigger && r.seqerr ##1 !flash_erase_out)
		else $error("operation not inhibited");
	AST_ALLOW_GATE: assert property (!r.allow |-> !flash_erase_out && !flash_prog_out)
		else $error("strobe active with operations inhibited");

	AST_ABORT_ERR: assert property (abort |=> r.seqerr && !r.trigger && !tmr_run)
		else $error("improper termination not flagged");
	AST_ERR_STATUS: assert property (err_evt |=> r.seqerr && r.stat[IRQ_ERR_BIT])
		else $error("sequence error not recorded");
	AST_ERR_STICKY: assert property (r.seqerr && !(wr_en && wr_addr == OFS_CTL && wr_strb[1]
		&& !wr_data[CTL_ERR_BIT]) |=> r.seqerr)
		else $error("sequence error flag lost without a clear");
	AST_ERASE_RUN: assert property (seq_good_start ##0 (n.erase && n.op == OP_PAGE_ERASE)
		|=> seq_erase_run[*3])
		else $error("page erase did not run");
	AST_MODE_FROZEN: assert property (r.state != FPEC_IDLE |=> $stable(r.erase) && $stable(r.op))
		else $error("mode or code changed during an operation");
	AST_NOP_CODES: assert property (seq_good_start ##0 (n.erase && (n.op == OP_NOP_A || n.op == OP_NOP_B
		|| n.op == OP_NOP_C)) |=> !r.trigger && (!r.seqerr || $past(r.seqerr)) ##1 !flash_erase_out)
		else $error("no-operation code started something");
	AST_RESERVED: assert property (seq_good_start ##0 (n.op == OP_RSV_A || n.op == OP_RSV_B)
		|=> !r.trigger [*2])
		else $error("reserved code started something");
	AST_SOFT_KEEP: assert property (soft_rst_in && !wr_en && !tmr_done && !abort
		|=> $stable(r.allow) && $stable(r.op) && $stable(r.trigger))
		else $error("control bits changed on non power-on reset");
	AST_UNIMPL_ZERO: assert property ((ctl_word & ~CTL_IMPL_MASK) == 16'h0000)
		else $error("unimplemented control bits not zero");
	AST_KEY_NEEDED: assert property (attempt && r.key != FPEC_KEY_OPEN
		|=> r.seqerr && !r.trigger && r.key == FPEC_KEY_NONE)
		else $error("start without unlock");
	AST_PROG_RUN: assert property (seq_good_start ##0 (!n.erase && n.op == PROG_OP_CODE)
		|=> seq_prog_run[*3])
		else $error("program did not run");
endmodule
`default_nettype wire

// [hw/fpec_pkg.sv]
// Purpose: constants and types of the flash program/erase control block
// Assumes: 20 MHz system clock, AXI4-Lite register access
// Notes: times are in microseconds, counts derived from the clock rate
// Overview of operation
// - set trigger starts timed operation, hardware clears
// - software can only set trigger, never clear
// - trigger reads zero whenever sequencer idle
// - allow bit clear inhibits every operation
// - bad sequence or termination sets error flag
// - erase-select one runs erase on trigger
// - code 0010 page erase; 1111/1011/0011 nothing
// - reserved and undefined codes do nothing
// - control bits reset by power-on only
// - bits 12..7 and 5..4 read zero
package fpec_pkg;
	localparam int CLK_MHZ = 20;
	localparam int PROG_TIME_US = 20;
	localparam int ERASE_TIME_US = 20000;
	localparam int PROG_CYC_DEF = PROG_TIME_US * CLK_MHZ;
	localparam int ERASE_CYC_DEF = ERASE_TIME_US * CLK_MHZ;
	localparam int TMR_W = 24;
	localparam int AXI_AW = 8;
	localparam logic [AXI_AW-1:0] OFS_CTL = 8'h00;
	localparam logic [AXI_AW-1:0] OFS_STAT = 8'h04;
	localparam logic [AXI_AW-1:0] OFS_MASK = 8'h08;
	localparam logic [AXI_AW-1:0] OFS_KEY = 8'h0C;
	localparam int CTL_TRIG_BIT = 15;
	localparam int CTL_ALLOW_BIT = 14;
	localparam int CTL_ERR_BIT = 13;
	localparam int CTL_ERASE_BIT = 6;
	localparam int CTL_OP_LSB = 0;
	localparam int CTL_OP_MSB = 3;
	localparam logic [15:0] CTL_IMPL_MASK = 16'hE04F;
	localparam logic [3:0] OP_PAGE_ERASE = 4'h2;
	localparam logic [3:0] OP_NOP_A = 4'hF;
	localparam logic [3:0] OP_NOP_B = 4'hB;
	localparam logic [3:0] OP_NOP_C = 4'h3;
	localparam logic [3:0] OP_RSV_A = 4'h1;
	localparam logic [3:0] OP_RSV_B = 4'h0;
	localparam logic [3:0] PROG_OP_DEF = 4'h3;
	localparam logic [15:0] KEY1_DEF = 16'h0055;
	localparam logic [15:0] KEY2_DEF = 16'h00AA;
	localparam int IRQ_DONE_BIT = 0;
	localparam int IRQ_ERR_BIT = 1;
	localparam int IRQ_W = 2;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {
		FPEC_IDLE = 2'b00,
		FPEC_ERASE = 2'b01,
		FPEC_PROG = 2'b10
	} fpec_seq_type;
	typedef enum logic [1:0] {
		FPEC_KEY_NONE = 2'b00,
		FPEC_KEY_HALF = 2'b01,
		FPEC_KEY_OPEN = 2'b10
	} fpec_key_type;
endpackage

// [hw/fpec_timer.sv]
// Purpose: self-timing counter for one flash operation
// Assumes: start and abort come from logic on the same clock
// Notes: done pulses exactly cycles_in edges after the start edge
`timescale 1ns/1ps
`default_nettype none
module fpec_timer import fpec_pkg::*; #(
	parameter int W = TMR_W
) (
	input wire logic clk_in,
	input wire logic nrst_in,
	input wire logic start_in,
	input wire logic abort_in,
	input wire logic [W-1:0] cycles_in,
	output logic done_out,
	output logic running_out
);
	typedef struct packed {
		logic [W-1:0] cnt;
		logic run;
		logic done;
	} fpec_tmr_type;
	fpec_tmr_type r, n;
	always_comb begin
		n = r;
		n.done = 1'b0;
		if (start_in) begin
			n.cnt = cycles_in;
			n.run = 1'b1;
		end else if (abort_in) begin
			n.run = 1'b0;
		end else if (r.run) begin
			n.cnt = r.cnt - 1'b1;
			if (r.cnt <= W'(1)) begin
				n.run = 1'b0;
				n.done = 1'b1;
			end
		end
	end
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end
	assign done_out = r.done;
	assign running_out = r.run;
endmodule
`default_nettype wire

// [hw/fpec_axil.sv]
// Purpose: AXI4-Lite slave front end for the register file
// Assumes: one write and one read outstanding at most
// Notes: write address and data taken in either order
`timescale 1ns/1ps
`default_nettype none
module fpec_axil import fpec_pkg::*; (
	input wire logic clk_in,
	input wire logic nrst_in,
	input wire logic [AXI_AW-1:0] awaddr_in,
	input wire logic awvalid_in,
	output logic awready_out,
	input wire logic [31:0] wdata_in,
	input wire logic [3:0] wstrb_in,
	input wire logic wvalid_in,
	output logic wready_out,
	output logic [1:0] bresp_out,
	output logic bvalid_out,
	input wire logic bready_in,
	input wire logic [AXI_AW-1:0] araddr_in,
	input wire logic arvalid_in,
	output logic arready_out,
	output logic [31:0] rdata_out,
	output logic [1:0] rresp_out,
	output logic rvalid_out,
	input wire logic rready_in,
	output logic wr_en_out,
	output logic [AXI_AW-1:0] wr_addr_out,
	output logic [31:0] wr_data_out,
	output logic [3:0] wr_strb_out,
	input wire logic wr_err_in,
	output logic rd_en_out,
	output logic [AXI_AW-1:0] rd_addr_out,
	input wire logic [31:0] rd_data_in,
	input wire logic rd_err_in
);
	typedef struct packed {
		logic aw_have;
		logic [AXI_AW-1:0] aw_addr;
		logic w_have;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} fpec_axi_type;
	fpec_axi_type r, n;
	logic wr_go;
	logic rd_go;
	always_comb begin
		n = r;
		wr_go = r.aw_have && r.w_have && !r.bvalid;
		rd_go = arvalid_in && r.arready;
		if (awvalid_in && r.awready) begin
			n.aw_have = 1'b1;
			n.aw_addr = awaddr_in;
		end
		if (wvalid_in && r.wready) begin
			n.w_have = 1'b1;
			n.w_data = wdata_in;
			n.w_strb = wstrb_in;
		end
		if (r.bvalid && bready_in) begin
			n.bvalid = 1'b0;
		end
		if (wr_go) begin
			n.aw_have = 1'b0;
			n.w_have = 1'b0;
			n.bvalid = 1'b1;
			n.bresp = wr_err_in ? RESP_SLVERR : RESP_OKAY;
		end
		if (r.rvalid && rready_in) begin
			n.rvalid = 1'b0;
		end
		if (rd_go) begin
			n.rvalid = 1'b1;
			n.rdata = rd_err_in ? 32'h00000000 : rd_data_in;
			n.rresp = rd_err_in ? RESP_SLVERR : RESP_OKAY;
		end
		n.awready = !n.aw_have && !n.bvalid;
		n.wready = !n.w_have && !n.bvalid;
		n.arready = !n.rvalid;
	end
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end
	assign awready_out = r.awready;
	assign wready_out = r.wready;
	assign bvalid_out = r.bvalid;
	assign bresp_out = r.bresp;
	assign arready_out = r.arready;
	assign rvalid_out = r.rvalid;
	assign rdata_out = r.rdata;
	assign rresp_out = r.rresp;
	assign wr_en_out = wr_go;
	assign wr_addr_out = r.aw_addr;
	assign wr_data_out = r.w_data;
	assign wr_strb_out = r.w_strb;
	assign rd_en_out = rd_go;
	assign rd_addr_out = araddr_in;
endmodule
`default_nettype wire

// [tb/fpec_flash_model.sv]
// Purpose: flash array stand-in that measures each strobe pulse
// Assumes: strobes are clk_in-synchronous levels
// Notes: counts one operation at the falling edge of a strobe
`timescale 1ns/1ps
`default_nettype none
module fpec_flash_model (
	input wire logic clk_in,
	input wire logic erase_in,
	input wire logic prog_in,
	input wire logic [3:0] op_in,
	output logic [31:0] erase_len_out,
	output logic [31:0] prog_len_out,
	output logic [31:0] ops_out,
	output logic [3:0] op_seen_out
);
	logic [31:0] run_e;
	logic [31:0] run_p;
	initial begin
		run_e = 32'h0;
		run_p = 32'h0;
		erase_len_out = 32'h0;
		prog_len_out = 32'h0;
		ops_out = 32'h0;
		op_seen_out = 4'h0;
	end
	// self-timed length is whatever the strobe spans
	always @(posedge clk_in) begin
		if (erase_in || prog_in) begin
			op_seen_out <= op_in;
		end
		if (erase_in) begin
			run_e <= run_e + 32'h1;
		end else if (run_e != 32'h0) begin
			erase_len_out <= run_e;
			run_e <= 32'h0;
			ops_out <= ops_out + 32'h1;
		end
		if (prog_in) begin
			run_p <= run_p + 32'h1;
		end else if (run_p != 32'h0) begin
			prog_len_out <= run_p;
			run_p <= 32'h0;
			ops_out <= ops_out + 32'h1;
		end
	end
endmodule
`default_nettype wire

// [tb/fpec_top_test.sv]
// Purpose: self-checking bench of the flash program/erase sequencer
// Assumes: short operation counts so a run stays brief
// Notes: registers reached only through the AXI4-Lite port
`timescale 1ns/1ps
`default_nettype none
module fpec_top_test import fpec_pkg::*;;
	localparam int PC = 10;
	localparam int EC = 20;
	logic clk_in, nrst_in, soft_rst;
	logic [7:0] awaddr, araddr;
	logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb, f_op, op_seen;
	logic [1:0] bresp, rresp;
	logic f_erase, f_prog, irq;
	logic [31:0] e_len, p_len, ops;
	int fail_count = 0;
	int compares = 0;
	fpec_top #(.PROG_CYCLES(PC), .ERASE_CYCLES(EC)) dut (.clk_in(clk_in), .nrst_in(nrst_in),
		.soft_rst_in(soft_rst), .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
		.s_axi_awready_out(awready), .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb),
		.s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
		.s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready), .s_axi_araddr_in(araddr),
		.s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
		.s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
		.flash_erase_out(f_erase), .flash_prog_out(f_prog), .flash_op_out(f_op), .irq_out(irq));
	fpec_flash_model flash (.clk_in(clk_in), .erase_in(f_erase), .prog_in(f_prog), .op_in(f_op),
		.erase_len_out(e_len), .prog_len_out(p_len), .ops_out(ops), .op_seen_out(op_seen));
	// ****************
	// bus and compare tasks
	// ****************
	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
		@(posedge clk_in);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wstrb <= 4'h3;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk_in);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		bready <= 1'b0;
		check({30'h0, bresp}, {30'h0, er}, "bresp");
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er = RESP_OKAY);
		@(posedge clk_in);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk_in);
			if (arvalid && arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		rready <= 1'b0;
		check(rdata, exp, "rdata");
		check({30'h0, rresp}, {30'h0, er}, "rresp");
	endtask
	task automatic unlock();
		wr(OFS_KEY, {16'h0, KEY1_DEF});
		wr(OFS_KEY, {16'h0, KEY2_DEF});
	endtask
	task automatic wait_ops(input logic [31:0] n);
		int k;
		k = 0;
		while (ops !== n && k < 200) begin
			@(posedge clk_in);
			k++;
		end
		check(ops, n, "operation count");
	endtask
	// ****************
	// scenarios
	// ****************
	task automatic t_basic();
		rd(OFS_CTL, 32'h0);
		rd(8'h10, 32'h0, RESP_SLVERR);
		wr(8'h10, 32'hFFFF, RESP_SLVERR);
		wr(OFS_CTL, 32'h5FFF);
		rd(OFS_CTL, 32'h404F);
	endtask
	task automatic t_bad_start();
		wr(OFS_MASK, 32'h3);
		wr(OFS_CTL, 32'hC042);
		rd(OFS_CTL, 32'h6042);
		rd(OFS_STAT, 32'h2);
		check({31'h0, irq}, 32'h1, "irq on error");
		wr(OFS_STAT, 32'h2);
		wr(OFS_CTL, 32'h4042);
		rd(OFS_CTL, 32'h4042);
		check({31'h0, irq}, 32'h0, "irq cleared");
	endtask
	task automatic t_allow_off();
		wr(OFS_MASK, 32'h0);
		unlock();
		wr(OFS_CTL, 32'h8042);
		rd(OFS_CTL, 32'h2042);
		check(ops, 32'h0, "no operation");
		check({31'h0, irq}, 32'h0, "masked irq");
		wr(OFS_MASK, 32'h3);
		check({31'h0, irq}, 32'h1, "unmasked irq");
		wr(OFS_STAT, 32'h2);
		wr(OFS_CTL, 32'h4042);
	endtask
	task automatic t_erase();
		unlock();
		wr(OFS_CTL, 32'hC042);
		rd(OFS_CTL, 32'hC042);
		// a trigger of zero and a new code must not disturb the run
		wr(OFS_CTL, 32'h4000);
		rd(OFS_CTL, 32'hC042);
		wait_ops(32'h1);
		// the strobe also spans the cycle in which the timer reports done
		check(e_len, EC + 1, "erase length");
		check({28'h0, op_seen}, {28'h0, OP_PAGE_ERASE}, "erase code");
		rd(OFS_CTL, 32'h4042);
		rd(OFS_STAT, 32'h1);
		check({31'h0, irq}, 32'h1, "done irq");
		wr(OFS_STAT, 32'h1);
		check({31'h0, irq}, 32'h0, "done cleared");
	endtask
	task automatic t_nops();
		logic [3:0] codes [5];
		codes = '{OP_NOP_A, OP_NOP_B, OP_NOP_C, OP_RSV_A, OP_RSV_B};
		foreach (codes[i]) begin
			unlock();
			wr(OFS_CTL, {16'h0, 12'hC04, codes[i]});
			rd(OFS_CTL, {16'h0, 12'h404, codes[i]});
			check(ops, 32'h1, "no flash activity");
		end
	endtask
	task automatic t_prog();
		unlock();
		wr(OFS_CTL, {16'h0, 12'hC00, PROG_OP_DEF});
		wait_ops(32'h2);
		check(p_len, PC + 1, "program length");
		check({28'h0, op_seen}, {28'h0, PROG_OP_DEF}, "program code");
		rd(OFS_CTL, {16'h0, 12'h400, PROG_OP_DEF});
		wr(OFS_STAT, 32'h1);
	endtask
	task automatic t_abort();
		unlock();
		wr(OFS_CTL, 32'hC042);
		wr(OFS_CTL, 32'h0042);
		rd(OFS_CTL, 32'h2042);
		wait_ops(32'h3);
		check({31'h0, e_len < EC}, 32'h1, "cut short");
		rd(OFS_STAT, 32'h2);
		wr(OFS_STAT, 32'h2);
	endtask
	task automatic t_resets();
		wr(OFS_CTL, 32'h4042);
		unlock();
		@(posedge clk_in);
		soft_rst <= 1'b1;
		@(posedge clk_in);
		soft_rst <= 1'b0;
		rd(OFS_CTL, 32'h4042);
		wr(OFS_CTL, 32'hC042);
		rd(OFS_CTL, 32'h6042);
		@(posedge clk_in);
		nrst_in <= 1'b0;
		repeat (3) @(posedge clk_in);
		nrst_in <= 1'b1;
		rd(OFS_CTL, 32'h0);
	endtask
	task automatic print_verdict();
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// ****************
	// clock, reset, sequence
	// ****************
	initial begin
		clk_in = 1'b0;
		forever #25 clk_in = ~clk_in;
	end
	initial begin
		// a stuck handshake would otherwise hang the run
		repeat (20000) @(posedge clk_in);
		fail_count++;
		print_verdict();
	end
	initial begin
		{nrst_in, soft_rst, awvalid, wvalid, bready, arvalid, rready} = 7'h0;
		{awaddr, araddr, wdata, wstrb} = 52'h0;
		repeat (12) @(posedge clk_in);
		nrst_in <= 1'b1;
		t_basic();
		t_bad_start();
		t_allow_off();
		t_erase();
		t_nops();
		t_prog();
		t_abort();
		t_resets();
		print_verdict();
	end
endmodule
`default_nettype wire
